/* logic/rtccs_top.sv */
/*
 Real-time count register with APB access, shared byte latch, period
 wrap with overflow interrupt, and synchronised count writes.
 Assumes one 250 MHz clock; the real-time rate is a divided tick.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rtccs_defs.svh"

module rtccs_top #(
	parameter int TICK_DIV = `RTCCS_TICK_DIV
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq
);
	import rtccs_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rstSync;
	logic rstn;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstn = rstSync[1];

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	rtccs_state_t state;
	rtccs_state_t next_state;
	logic tick;
	logic setup;
	logic access;
	logic wrAcc;
	logic rdAcc;
	logic [`RTCCS_IDX_W-1:0] idx;
	logic aligned;
	logic mapped;
	logic syncStart;
	logic syncBusy;
	logic syncApply;
	rtccs_word_t syncValue;
	rtccs_word_t startValue;
	logic wrapHit;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign idx = paddr[7:2];
	assign aligned = paddr[1:0] == 2'h0;
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wrAcc = access & pwrite & ~state.err;
	assign rdAcc = access & ~pwrite & ~state.err;

	always_comb begin
		case (idx)
			`RTCCS_IDX_CTRL, `RTCCS_IDX_STATUS, `RTCCS_IDX_MASK,
			`RTCCS_IDX_FLAGS, `RTCCS_IDX_TEMP, `RTCCS_IDX_COUNT_LOW_BYTE,
			`RTCCS_IDX_COUNT_HIGH_BYTE, `RTCCS_IDX_PERL, `RTCCS_IDX_PERH: begin
				mapped = aligned;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Data is registered at setup, so every access has one wait-free
	// access phase and no read path runs straight from the counter.
	assign pready = 1'b1;
	assign pslverr = access & state.err;
	assign prdata = state.rdData;
	assign irq = state.flag & state.mask;

	// ------------------------------------------------------------
	// Real-time tick
	// ------------------------------------------------------------
	assign tick = state.divCnt == 16'(TICK_DIV - 1);

	// ------------------------------------------------------------
	// Count write crossing
	// ------------------------------------------------------------
	assign syncStart = wrAcc && idx == `RTCCS_IDX_COUNT_HIGH_BYTE;
	assign startValue = {pwdata[7:0], state.temp};

	rtccs_sync u_sync (
		.clock(clock),
		.rstn(rstn),
		.tick(tick),
		.start(syncStart),
		.startValue(startValue),
		.busy(syncBusy),
		.apply(syncApply),
		.value(syncValue)
	);

	assign wrapHit = state.enable && tick && !syncApply
		&& state.count == state.period;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.divCnt = tick ? 16'h0000 : state.divCnt + 16'h0001;

		// Counting; a synchronised load replaces the tick's step
		if (syncApply) begin
			next_state.count = syncValue;
		end else if (state.enable && tick) begin
			if (wrapHit) begin
				next_state.count = `RTCCS_CNT_RST;
			end else begin
				next_state.count = state.count + 16'h0001;
			end
		end

		// Setup phase: capture read data and the error answer
		if (setup) begin
			next_state.err = ~mapped;
			next_state.rdData = 32'h0000_0000;
			case (idx)
				`RTCCS_IDX_CTRL: begin
					next_state.rdData[`RTCCS_BIT_EN] = state.enable;
				end
				`RTCCS_IDX_STATUS: begin
					next_state.rdData[`RTCCS_BIT_COUNT_SYNC_BUSY_FLAG] = syncBusy;
				end
				`RTCCS_IDX_MASK: begin
					next_state.rdData[`RTCCS_BIT_OVF] = state.mask;
				end
				`RTCCS_IDX_FLAGS: begin
					next_state.rdData[`RTCCS_BIT_OVF] = state.flag;
				end
				`RTCCS_IDX_TEMP: begin
					next_state.rdData[7:0] = state.temp;
				end
				`RTCCS_IDX_COUNT_LOW_BYTE: begin
					next_state.rdData[7:0] = state.count[7:0];
				end
				`RTCCS_IDX_COUNT_HIGH_BYTE: begin
					next_state.rdData[7:0] = state.temp;
				end
				`RTCCS_IDX_PERL: begin
					next_state.rdData[7:0] = state.period[7:0];
				end
				`RTCCS_IDX_PERH: begin
					next_state.rdData[7:0] = state.temp;
				end
				default: begin
					next_state.rdData = 32'h0000_0000;
				end
			endcase
			// Unaligned hits on a mapped index answer zero as well
			if (!mapped) begin
				next_state.rdData = 32'h0000_0000;
			end
			// High byte latched from the same snapshot as the low byte,
			// so a tick between setup and access cannot tear the pair
			if (mapped && !pwrite && idx == `RTCCS_IDX_COUNT_LOW_BYTE) begin
				next_state.temp = state.count[15:8];
			end
		end

		// Access phase: period low-byte reads latch the high byte
		if (rdAcc) begin
			case (idx)
				`RTCCS_IDX_PERL: begin
					next_state.temp = state.period[15:8];
				end
				default: begin
					next_state.temp = state.temp;
				end
			endcase
		end

		// Access phase writes
		if (wrAcc) begin
			case (idx)
				`RTCCS_IDX_CTRL: begin
					next_state.enable = pwdata[`RTCCS_BIT_EN];
				end
				`RTCCS_IDX_MASK: begin
					next_state.mask = pwdata[`RTCCS_BIT_OVF];
				end
				`RTCCS_IDX_FLAGS: begin
					if (pwdata[`RTCCS_BIT_OVF]) begin
						next_state.flag = 1'b0;
					end
				end
				`RTCCS_IDX_TEMP, `RTCCS_IDX_COUNT_LOW_BYTE, `RTCCS_IDX_PERL: begin
					next_state.temp = pwdata[7:0];
				end
				`RTCCS_IDX_PERH: begin
					next_state.period = {pwdata[7:0], state.temp};
				end
				default: begin
					next_state.temp = state.temp;
				end
			endcase
		end

		// Overflow set wins over a clear in the same cycle
		if (wrapHit) begin
			next_state.flag = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= '{
				divCnt: 16'h0000,
				enable: 1'b0,
				mask: 1'b0,
				flag: 1'b0,
				temp: `RTCCS_TEMP_RST,
				count: `RTCCS_CNT_RST,
				period: `RTCCS_PER_RST,
				rdData: 32'h0000_0000,
				err: 1'b0
			};
		end else begin
			state <= next_state;
		end
	end
endmodule

`default_nettype wire

/* include/rtccs_defs.svh */
/*
 Constants for the real-time count register block: register indices,
 field positions, reset values and timing counts.
 Assumes it is included by its bare name before the package and modules.
*/
// Behaviour
// - Count is one 16-bit value, two bytes.
// - Count low byte sits at offset 0x08.
// - Count high byte sits one above it.
// - Written count applies two ticks later.
// - Status bit 1 high while count syncs.
// - One shared byte latch at 0x4.
// - Count at period wraps, sets overflow.
`ifndef RTCCS_DEFS_SVH
`define RTCCS_DEFS_SVH

// ------------------------------------------------------------
// Register indices, byte address is four times the index
// ------------------------------------------------------------
`define RTCCS_IDX_W 6
`define RTCCS_IDX_CTRL 6'h00
`define RTCCS_IDX_STATUS 6'h01
`define RTCCS_IDX_MASK 6'h02
`define RTCCS_IDX_FLAGS 6'h03
`define RTCCS_IDX_TEMP 6'h04
`define RTCCS_IDX_COUNT_LOW_BYTE 6'h08
`define RTCCS_IDX_COUNT_HIGH_BYTE 6'h09
`define RTCCS_IDX_PERL 6'h0a
`define RTCCS_IDX_PERH 6'h0b

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RTCCS_BIT_EN 0
`define RTCCS_BIT_COUNT_SYNC_BUSY_FLAG 1
`define RTCCS_BIT_OVF 0

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define RTCCS_CNT_RST 16'h0000
`define RTCCS_PER_RST 16'hffff
`define RTCCS_TEMP_RST 8'h00
`define RTCCS_SYNC_TICKS 2'h2
`define RTCCS_TICK_DIV 16

`endif

/* include/rtccs_pkg.sv */
/*
 Types of the real-time count register block.
 Assumes rtccs_defs.svh is on the include path.
*/
`include "rtccs_defs.svh"

package rtccs_pkg;
	typedef logic [15:0] rtccs_word_t;
	typedef logic [7:0] rtccs_byte_t;

	typedef struct packed {
		logic pending;
		logic [1:0] ticks;
		rtccs_word_t value;
	} rtccs_sync_t;

	typedef struct packed {
		logic [15:0] divCnt;
		logic enable;
		logic mask;
		logic flag;
		rtccs_byte_t temp;
		rtccs_word_t count;
		rtccs_word_t period;
		logic [31:0] rdData;
		logic err;
	} rtccs_state_t;
endpackage

/* logic/rtccs_sync.sv */
/*
 Carries a written count value into the tick domain of the counter.
 Assumes tick is a one-cycle enable pulse of the real-time rate.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rtccs_defs.svh"

module rtccs_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Tick domain
	input wire logic tick,
	// Load request
	input wire logic start,
	input wire rtccs_pkg::rtccs_word_t startValue,
	// Result
	output logic busy,
	output logic apply,
	output rtccs_pkg::rtccs_word_t value
);
	import rtccs_pkg::*;

	rtccs_sync_t state;
	rtccs_sync_t next_state;
	logic lastTick;

	// ------------------------------------------------------------
	// Tick counting
	// ------------------------------------------------------------
	assign lastTick = state.ticks == (`RTCCS_SYNC_TICKS - 2'h1);
	assign apply = state.pending & tick & lastTick;
	assign busy = state.pending;
	assign value = state.value;

	always_comb begin
		next_state = state;
		if (start) begin
			// A new write restarts the crossing with the latest value
			next_state.pending = 1'b1;
			next_state.ticks = 2'h0;
			next_state.value = startValue;
		end else if (state.pending && tick) begin
			if (lastTick) begin
				next_state.pending = 1'b0;
				next_state.ticks = 2'h0;
			end else begin
				next_state.ticks = state.ticks + 2'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= '{pending: 1'b0, ticks: 2'h0, value: `RTCCS_CNT_RST};
		end else begin
			state <= next_state;
		end
	end
endmodule

`default_nettype wire

/* verif/rtccs_top_monitor.sv */
/*
 Port checker for the real-time count register block.
 Assumes it is bound to rtccs_top and sees an APB master.
*/
`timescale 1ns/1ns
`default_nettype none

module rtccs_top_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Interrupt
	input wire logic irq
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	logic bad;
	assign bad = paddr[1:0] != 2'h0
		|| paddr[7:2] inside {[6'h05:6'h07], [6'h0c:6'h3f]};
	sequence cnthWr;
		psel && penable && pwrite && paddr == 8'h24;
	endsequence
	sequence statSetup;
		psel && !penable && !pwrite && paddr == 8'h04;
	endsequence
	err_place_a: assert property (psel && penable && bad |-> pslverr)
		else $error("no error on unmapped access");
	err_quiet_a: assert property (psel && penable && !bad |-> !pslverr)
		else $error("error on mapped access");
	err_idle_a: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access");
	ready_now_a: assert property (psel && penable |-> pready)
		else $error("access phase not answered");
	rd_zero_a: assert property (psel && !penable && bad |=> prdata == 0)
		else $error("data on unmapped read");
	rd_hold_a: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved");
	rd_byte_a: assert property (psel && penable |-> prdata[31:8] == 0)
		else $error("upper read bits set");
	busy_set_a: assert property (cnthWr ##1 statSetup |=> prdata[1])
		else $error("busy not set after count write");
	stat_bits_a: assert property (statSetup |=> prdata[31:2] == 0)
		else $error("stray status bits");
	irq_clear_a: assert property (psel && penable && pwrite
		&& (paddr == 8'h0c && pwdata[0] || paddr == 8'h08 && !pwdata[0])
		|=> !irq) else $error("irq after clear or mask");
endmodule

`default_nettype wire

/* verif/rtccs_bench.sv */
/*
 Self-checking bench for the real-time count register block.
 Assumes rtccs_top and its checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none

module rtccs_bench;
	// ------------------------------------------------------------
	// Stimulus and checks
	// ------------------------------------------------------------
	// Short tick keeps the run brief
	localparam int TD = 4;
	logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, er;
	logic [15:0] v;
	logic [7:0] badA [4] = '{8'h14, 8'h21, 8'h1c, 8'hfc};
	int error_cnt = 0, num_checks = 0, cyc = 0, t0, i, n;
	always #2 clock = ~clock;
	rtccs_top #(.TICK_DIV(TD)) dut (.clock, .resetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Leaves psel up so a setup may follow at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
	endtask
	task idle;
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask
	task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(nm, rd, e);
	endtask
	task waitsync;
		i = 0;
		do begin
			apb(0, 8'h04, 0);
			i++;
		end while (rd[1] === 1'b1);
		idle;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim;
		end
	end
	initial begin
		void'($urandom(32'h1706));
		repeat (3) @(posedge clock);
		resetn <= 1;
		repeat (3) @(posedge clock);
		rc("temp", 8'h10, 0);
		rc("count_low_byte", 8'h20, 0);
		rc("count_high_byte", 8'h24, 0);
		rc("perl", 8'h28, 8'hff);
		rc("perh", 8'h2c, 8'hff);
		rc("status", 8'h04, 0);
		rc("flags", 8'h0c, 0);
		for (i = 0; i < 4; i++) begin
			rc("unmapped", badA[i], 0);
			chk("rderr", er, 1);
			apb(1, badA[i], 32'hff);
			chk("wrerr", er, 1);
		end
		for (n = 0; n < 4; n++) begin
			v = (n == 0) ? 16'hffff : 16'($urandom);
			apb(1, 8'h20, {24'h0, v[7:0]});
			rc("tmp", 8'h10, v[7:0]);
			apb(1, 8'h24, {24'h0, v[15:8]});
			t0 = cyc;
			rc("busy", 8'h04, 2);
			waitsync;
			chk("lat", cyc - t0 >= TD + 4 && cyc - t0 <= 2 * TD + 4, 1);
			rc("count_low_byte", 8'h20, v[7:0]);
			rc("count_high_byte", 8'h24, v[15:8]);
		end
		apb(1, 8'h28, 3);
		apb(1, 8'h2c, 0);
		apb(1, 8'h20, 0);
		apb(1, 8'h24, 0);
		waitsync;
		apb(1, 8'h08, 1);
		apb(1, 8'h00, 1);
		idle;
		i = 0;
		while (irq !== 1'b1 && i < 100) begin
			@(posedge clock);
			i++;
		end
		chk("wrap", i >= 3 * TD - 2 && i <= 4 * TD, 1);
		rc("flag", 8'h0c, 1);
		apb(1, 8'h0c, 1);
		idle;
		chk("irqclr", irq, 0);
		apb(1, 8'h08, 0);
		repeat (20) idle;
		rc("flag2", 8'h0c, 1);
		chk("irqmask", irq, 0);
		apb(1, 8'h00, 0);
		apb(1, 8'h28, 8'hff);
		apb(1, 8'h2c, 8'hff);
		apb(1, 8'h20, 0);
		apb(1, 8'h24, 0);
		waitsync;
		apb(1, 8'h00, 1);
		repeat (39) idle;
		apb(1, 8'h00, 0);
		apb(0, 8'h20, 0);
		chk("ticks", rd >= 9 && rd <= 11, 1);
		rc("cnthi", 8'h24, 0);
		apb(1, 8'h10, 8'h5a);
		rc("tempw", 8'h10, 8'h5a);
		// Count runs across a carry while pairs are read, gaps vary phase
		apb(1, 8'h20, 8'hfa);
		apb(1, 8'h24, 0);
		waitsync;
		apb(1, 8'h00, 1);
		rc("ctrl", 8'h00, 1);
		rc("mask", 8'h08, 0);
		for (n = 0; n < 8; n++) begin
			apb(0, 8'h20, 0);
			v[7:0] = rd[7:0];
			apb(0, 8'h24, 0);
			v[15:8] = rd[7:0];
			idle;
			chk("pair", v >= 16'h00fa && v <= 16'h0108, 1);
		end
		apb(1, 8'h00, 0);
		idle;
		end_sim;
	end
endmodule

bind rtccs_top rtccs_top_monitor mon (.clock, .resetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

`default_nettype wire
